// [rtl/cfdsw_consts.vh]
// register offsets, field positions, reset values and timing counts for the clock fail block
`ifndef CFDSW_CONSTS_VH
`define CFDSW_CONSTS_VH
`define CFDSW_OFF_CCR0 12'h000
`define CFDSW_OFF_CCR1 12'h004
`define CFDSW_OFF_CCR3 12'h008
`define CFDSW_OFF_FDCR 12'h00C
`define CFDSW_OFF_OSCR 12'h010
`define CFDSW_OFF_PROT 12'h014
`define CFDSW_OFF_STAT 12'h018
// control register zero
`define CFDSW_B_WAITPCS 2
`define CFDSW_B_MOSCSTP 5
`define CFDSW_B_DIV8 6
// control register one
`define CFDSW_B_ALLSTOP 0
`define CFDSW_B_LSOSTP 4
// control register three
`define CFDSW_B_WAITEN 0
`define CFDSW_B_WDOVR 5
// detection control register
`define CFDSW_B_FDEN_LO 0
`define CFDSW_B_FDEN_HI 1
`define CFDSW_B_ONCHSEL 2
`define CFDSW_B_MSTOP 3
// onchip oscillator register
`define CFDSW_B_HSRUN 0
`define CFDSW_B_SPDSEL 1
// protect register
`define CFDSW_B_PROT0 0
`define CFDSW_PROT_MASK 8'h0F
// status register
`define CFDSW_B_ST_STOP 0
`define CFDSW_B_ST_WAIT 1
`define CFDSW_B_ST_IRQ 2
`define CFDSW_B_ST_SHARED 3
// reset values and detection enable code
`define CFDSW_RST_CCR0 8'h40
`define CFDSW_RST_CCR1 8'h20
`define CFDSW_RST_CCR3 8'h00
`define CFDSW_RST_FDCR 8'h04
`define CFDSW_RST_OSCR 8'h00
`define CFDSW_FDEN_ON 2'b11
// timing
`define CFDSW_LSO_DIV 16'h0007
`define CFDSW_FAIL_WIN 8'h04
`endif

// [rtl/cfdsw_sync2.v]
// two-flop synchroniser for one asynchronous level
`default_nettype none
module cfdsw_sync2 (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // level
  input wire d,
  output reg q
);
  reg meta_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// [rtl/cfdsw_edge_win.v]
// stall watchdog: flags when no input edge occurs within a window of ticks
`default_nettype none
module cfdsw_edge_win #(
  parameter [7:0] WIN = 8'h04
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire enable,
  input wire tick,
  input wire sig_sync,
  // result
  output reg stalled
);
  reg prev_r;
  reg seen_r;
  reg [7:0] cnt_r;
  wire edge_w = sig_sync ^ prev_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_r <= 1'b0;
      seen_r <= 1'b0;
      cnt_r <= 8'h00;
      stalled <= 1'b0;
    end else begin
      prev_r <= sig_sync;
      stalled <= 1'b0;
      if (!enable) begin
        seen_r <= 1'b0;
        cnt_r <= 8'h00;
      end else if (edge_w) begin
        seen_r <= 1'b1;
        cnt_r <= 8'h00;
      end else if (tick) begin
        if (cnt_r >= WIN - 8'h01) begin
          stalled <= 1'b1;
          cnt_r <= 8'h00;
        end else begin
          cnt_r <= cnt_r + 8'h01;
        end
      end
    end
  end
endmodule
`default_nettype wire

// [rtl/cfdsw_top.v]
// clock fail detection, stop/wait control and clock write protection with apb registers
`include "cfdsw_consts.vh"
`default_nettype none
module cfdsw_top #(
  parameter [15:0] LSO_DIV = `CFDSW_LSO_DIV,
  parameter [7:0] FAIL_WIN = `CFDSW_FAIL_WIN
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // clock sources
  input wire main_crystal_clock,
  // wake and shared interrupt sources
  input wire periph_irq_req,
  input wire watchdog_source_flag,
  input wire volt_mon1_source_flag,
  input wire volt_mon2_source_flag,
  // clock control outputs
  output reg cpu_clk_en,
  output reg periph_clk_en,
  output reg onchip_source_select,
  output reg low_speed_osc_run,
  output reg high_speed_osc_run,
  output reg main_osc_run,
  output reg sysclk_div8,
  output reg stop_mode,
  output reg wait_mode,
  output reg fail_irq,
  output reg irq_seq_start
);
  localparam [2:0] ST_RUN = 3'b001;
  localparam [2:0] ST_STOP = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  reg [7:0] ccr0_r;
  reg [7:0] ccr1_r;
  reg [7:0] ccr3_r;
  reg [7:0] fdcr_r;
  reg [7:0] oscr_r;
  reg [7:0] prot_r;
  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [15:0] div_r;
  reg lso_tick_r;
  reg clk_restart_r;
  reg [31:0] rd_nxt;

  wire xtal_sync;
  wire irq_sync;
  wire stalled;

  cfdsw_sync2 u_sync_xtal (
    .pclk(pclk),
    .presetn(presetn),
    .d(main_crystal_clock),
    .q(xtal_sync)
  );

  cfdsw_sync2 u_sync_irq (
    .pclk(pclk),
    .presetn(presetn),
    .d(periph_irq_req),
    .q(irq_sync)
  );

  wire wr_acc = psel && penable && pwrite && pready;
  wire rd_acc = psel && !penable && !pwrite;
  wire wr_lane0 = wr_acc && pstrb[0];
  wire [7:0] wb = pwdata[7:0];
  wire clk_wr_ok = prot_r[`CFDSW_B_PROT0];
  wire wr_ccr0 = wr_lane0 && clk_wr_ok && (paddr == `CFDSW_OFF_CCR0);
  wire wr_ccr1 = wr_lane0 && clk_wr_ok && (paddr == `CFDSW_OFF_CCR1);
  wire wr_ccr3 = wr_lane0 && clk_wr_ok && (paddr == `CFDSW_OFF_CCR3);
  wire wr_fdcr = wr_lane0 && clk_wr_ok && (paddr == `CFDSW_OFF_FDCR);
  wire wr_oscr = wr_lane0 && clk_wr_ok && (paddr == `CFDSW_OFF_OSCR);
  wire wr_prot = wr_lane0 && (paddr == `CFDSW_OFF_PROT);

  wire [1:0] fden = fdcr_r[`CFDSW_B_FDEN_HI:`CFDSW_B_FDEN_LO];
  wire det_on = (fden == `CFDSW_FDEN_ON);
  wire on_xtal = !fdcr_r[`CFDSW_B_ONCHSEL];
  wire det_arm = det_on && on_xtal && (state_r == ST_RUN);
  wire fail_evt = det_arm && stalled;
  wire fail_src = fdcr_r[`CFDSW_B_MSTOP] || (det_on && fdcr_r[`CFDSW_B_ONCHSEL]);

  cfdsw_edge_win #(
    .WIN(FAIL_WIN)
  ) u_win (
    .pclk(pclk),
    .presetn(presetn),
    .enable(det_arm),
    .tick(lso_tick_r),
    .sig_sync(xtal_sync),
    .stalled(stalled)
  );

  // low-speed oscillator time base as an enable pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_r <= 16'h0000;
      lso_tick_r <= 1'b0;
    end else begin
      lso_tick_r <= 1'b0;
      if (div_r >= LSO_DIV) begin
        div_r <= 16'h0000;
        lso_tick_r <= 1'b1;
      end else begin
        div_r <= div_r + 16'h0001;
      end
    end
  end

  // power mode sequencing
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        // entry one edge after the write
        if (ccr1_r[`CFDSW_B_ALLSTOP]) begin
          state_nxt = ST_STOP;
        end else if (ccr3_r[`CFDSW_B_WAITEN]) begin
          state_nxt = ST_WAIT;
        end
      end
      ST_STOP: begin
        if (irq_sync) begin
          state_nxt = ST_RUN;
        end
      end
      ST_WAIT: begin
        if (irq_sync) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_RUN;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_RUN;
      clk_restart_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      clk_restart_r <= (state_r != ST_RUN) && (state_nxt == ST_RUN);
    end
  end

  // register file
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ccr0_r <= `CFDSW_RST_CCR0;
      ccr1_r <= `CFDSW_RST_CCR1;
      ccr3_r <= `CFDSW_RST_CCR3;
      fdcr_r <= `CFDSW_RST_FDCR;
      oscr_r <= `CFDSW_RST_OSCR;
      prot_r <= 8'h00;
    end else begin
      if (wr_ccr0) begin
        ccr0_r <= wb;
      end
      if (wr_ccr1) begin
        ccr1_r <= wb;
      end
      if (wr_ccr3) begin
        ccr3_r <= wb;
      end
      if (wr_oscr) begin
        oscr_r <= wb;
      end
      // protect bit kept until software clears it
      if (wr_prot) begin
        prot_r <= wb & `CFDSW_PROT_MASK;
      end
      if (wr_ccr1 && wb[`CFDSW_B_ALLSTOP]) begin
        ccr0_r[`CFDSW_B_DIV8] <= 1'b1;
      end
      if (wr_fdcr) begin
        fdcr_r[1:0] <= wb[1:0];
        fdcr_r[`CFDSW_B_ONCHSEL] <= wb[`CFDSW_B_ONCHSEL];
        // stopped flag is write-zero-to-clear
        if (!wb[`CFDSW_B_MSTOP]) begin
          fdcr_r[`CFDSW_B_MSTOP] <= 1'b0;
        end
      end
      // wake clears the entry bits; divide-by-8 stays set
      if (state_r != ST_RUN && state_nxt == ST_RUN) begin
        ccr1_r[`CFDSW_B_ALLSTOP] <= 1'b0;
        ccr3_r[`CFDSW_B_WAITEN] <= 1'b0;
        // wake clock is previous divided by 8
        if (state_r == ST_STOP) begin
          ccr0_r[`CFDSW_B_DIV8] <= 1'b1;
        end
      end
      // hardware set wins over software clear
      if (fail_evt) begin
        fdcr_r[`CFDSW_B_ONCHSEL] <= 1'b1;
        fdcr_r[`CFDSW_B_MSTOP] <= 1'b1;
        ccr1_r[`CFDSW_B_LSOSTP] <= 1'b0;
      end
    end
  end

  // apb read mux
  always @* begin
    rd_nxt = 32'h0000_0000;
    case (paddr)
      `CFDSW_OFF_CCR0: rd_nxt[7:0] = ccr0_r;
      `CFDSW_OFF_CCR1: rd_nxt[7:0] = ccr1_r;
      `CFDSW_OFF_CCR3: rd_nxt[7:0] = ccr3_r;
      `CFDSW_OFF_FDCR: rd_nxt[7:0] = fdcr_r;
      `CFDSW_OFF_OSCR: rd_nxt[7:0] = oscr_r;
      `CFDSW_OFF_PROT: rd_nxt[7:0] = prot_r;
      `CFDSW_OFF_STAT: begin
        rd_nxt[`CFDSW_B_ST_STOP] = (state_r == ST_STOP);
        rd_nxt[`CFDSW_B_ST_WAIT] = (state_r == ST_WAIT);
        rd_nxt[`CFDSW_B_ST_IRQ] = fail_src;
        rd_nxt[`CFDSW_B_ST_SHARED] = watchdog_source_flag | volt_mon1_source_flag |
                                     volt_mon2_source_flag;
      end
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  wire addr_ok = (paddr == `CFDSW_OFF_CCR0) || (paddr == `CFDSW_OFF_CCR1) ||
                 (paddr == `CFDSW_OFF_CCR3) || (paddr == `CFDSW_OFF_FDCR) ||
                 (paddr == `CFDSW_OFF_OSCR) || (paddr == `CFDSW_OFF_PROT) ||
                 (paddr == `CFDSW_OFF_STAT);

  // no wait state: pready raised in the first access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addr_ok;
      if (rd_acc) begin
        prdata <= rd_nxt;
      end
    end
  end

  // registered clock controls
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      onchip_source_select <= 1'b1;
      low_speed_osc_run <= 1'b1;
      high_speed_osc_run <= 1'b0;
      main_osc_run <= 1'b0;
      sysclk_div8 <= 1'b1;
      stop_mode <= 1'b0;
      wait_mode <= 1'b0;
      fail_irq <= 1'b0;
      irq_seq_start <= 1'b0;
    end else begin
      cpu_clk_en <= (state_r == ST_RUN);
      periph_clk_en <= (state_r == ST_RUN) ||
                       (state_r == ST_WAIT && !ccr0_r[`CFDSW_B_WAITPCS]);
      // source only returns to crystal by software
      onchip_source_select <= fdcr_r[`CFDSW_B_ONCHSEL];
      low_speed_osc_run <= !ccr1_r[`CFDSW_B_LSOSTP];
      high_speed_osc_run <= oscr_r[`CFDSW_B_HSRUN] && (state_r != ST_STOP);
      main_osc_run <= !ccr0_r[`CFDSW_B_MOSCSTP] && (state_r != ST_STOP);
      sysclk_div8 <= ccr0_r[`CFDSW_B_DIV8];
      stop_mode <= (state_r == ST_STOP);
      wait_mode <= (state_r == ST_WAIT);
      // level request while stopped flag set
      fail_irq <= fdcr_r[`CFDSW_B_MSTOP] || fail_evt;
      // sequence after request and clock restart
      irq_seq_start <= clk_restart_r && irq_sync;
    end
  end
endmodule
`default_nettype wire

// [tb/cfdsw_props.sv]
// port assertions for the clock fail block
`default_nettype none
module cfdsw_props (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // clocking
  input wire logic periph_irq_req,
  input wire logic cpu_clk_en,
  input wire logic onchip_source_select,
  input wire logic low_speed_osc_run,
  input wire logic sysclk_div8,
  input wire logic stop_mode,
  input wire logic fail_irq,
  input wire logic irq_seq_start
);
  wire logic wr_acc = psel & penable & pwrite & pready;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_next: assert property (psel && !penable |=> pready) else $error("late ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("stray error");
  a_stop_div8: assert property ($rose(stop_mode) |-> ##[0:1] sysclk_div8)
    else $error("stop without div8");
  a_stop_cpu_off: assert property (stop_mode |-> !cpu_clk_en)
    else $error("cpu clock in stop");
  a_stop_exit: assert property ($fell(stop_mode) |->
    $past(periph_irq_req, 1) || $past(periph_irq_req, 2)) else $error("spurious wake");
  a_seq_pulse: assert property (irq_seq_start |-> cpu_clk_en ##1 !irq_seq_start)
    else $error("bad irq sequence");
  a_fail_flags: assert property ($rose(fail_irq) |->
    ##[0:1] (onchip_source_select && low_speed_osc_run)) else $error("fail flags");
  a_no_auto_back: assert property ($fell(onchip_source_select) |->
    $past(wr_acc, 1) || $past(wr_acc, 2)) else $error("switched back alone");
endmodule
bind cfdsw_top cfdsw_props i_props (.*);
`default_nettype wire

// [tb/cfdsw_xtal.sv]
// main crystal model, stoppable by the bench
`default_nettype none
module cfdsw_xtal (
  // control
  input wire logic osc_on,
  input wire logic broken,
  // crystal pin
  output var logic xtal
);
  timeunit 1ns;
  timeprecision 100ps;
  initial xtal = 1'b0;
  always #25 if (osc_on === 1'b1 && !broken) xtal = ~xtal;
endmodule
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the clock fail block
`include "cfdsw_consts.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h1;
  logic periph_irq_req = 1'b0, brk = 1'b0;
  logic watchdog_source_flag = 1'b0, volt_mon1_source_flag = 1'b0, volt_mon2_source_flag = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, main_crystal_clock, cpu_clk_en, periph_clk_en, onchip_source_select;
  logic low_speed_osc_run, high_speed_osc_run, main_osc_run, sysclk_div8, stop_mode, wait_mode;
  logic fail_irq, irq_seq_start, e;
  logic [7:0] r;
  int n, n_fail = 0, num_checks = 0;
  always #2.5 pclk = ~pclk;
  cfdsw_xtal i_xtal (.osc_on(main_osc_run), .broken(brk), .xtal(main_crystal_clock));
  cfdsw_top i_dut (.*);
  task automatic chk(input logic [8:0] g, input logic [8:0] x);
    num_checks++;
    if (g !== x) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, x);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic lim(input logic ok);
    if (ok !== 1'b1) begin
      n_fail++;
      $display("wrong value at %0t: wait expired", $time);
      print_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h00_0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata[7:0];
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    lim(pready);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [7:0] x, input logic xe);
    apb(1'b0, a, 8'h00);
    chk({e, r}, {xe, x});
  endtask
  task automatic t_regs();
    logic [11:0] a [5] = '{`CFDSW_OFF_CCR0, `CFDSW_OFF_CCR1, `CFDSW_OFF_CCR3,
      `CFDSW_OFF_FDCR, `CFDSW_OFF_OSCR};
    logic [7:0] v [5] = '{`CFDSW_RST_CCR0, `CFDSW_RST_CCR1, `CFDSW_RST_CCR3,
      `CFDSW_RST_FDCR, `CFDSW_RST_OSCR};
    logic [7:0] b [5] = '{8'h04, 8'h10, 8'h20, 8'h01, 8'h01};
    for (int i = 0; i < 5; i++) begin
      rdc(a[i], v[i], 1'b0);
      apb(1'b1, a[i], v[i] ^ b[i]);
      rdc(a[i], v[i], 1'b0);
    end
    apb(1'b1, `CFDSW_OFF_PROT, 8'h01);
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, a[i], v[i] ^ b[i]);
      rdc(a[i], v[i] ^ b[i], 1'b0);
      apb(1'b1, a[i], v[i]);
    end
    rdc(`CFDSW_OFF_PROT, 8'h01, 1'b0);
    rdc(12'h01C, 8'h00, 1'b1);
  endtask
  task automatic t_stop();
    apb(1'b1, `CFDSW_OFF_CCR0, 8'h00);
    apb(1'b1, `CFDSW_OFF_FDCR, 8'h00);
    // override bit already 0; wake source and flash mode set by software
    rdc(`CFDSW_OFF_CCR3, 8'h00, 1'b0);
    apb(1'b1, `CFDSW_OFF_CCR1, 8'h21);
    watchdog_source_flag <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(9'({stop_mode, cpu_clk_en, sysclk_div8}), 9'h005);
    chk(9'(main_osc_run), 9'h000);
    periph_irq_req <= 1'b1;
    watchdog_source_flag <= 1'b0;
    for (n = 0; n < 50 && irq_seq_start !== 1'b1; n++) @(posedge pclk);
    lim(irq_seq_start);
    chk(9'({stop_mode, cpu_clk_en, sysclk_div8}), 9'h003);
    rdc(`CFDSW_OFF_CCR1, 8'h20, 1'b0);
    rdc(`CFDSW_OFF_CCR0, 8'h40, 1'b0);
    periph_irq_req <= 1'b0;
  endtask
  task automatic t_wait();
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, `CFDSW_OFF_CCR0, p ? 8'h44 : 8'h40);
      apb(1'b1, `CFDSW_OFF_CCR3, 8'h01);
      repeat (4) @(posedge pclk);
      chk(9'({wait_mode, cpu_clk_en, periph_clk_en}), p ? 9'h004 : 9'h005);
      periph_irq_req <= 1'b1;
      for (n = 0; n < 50 && wait_mode !== 1'b0; n++) @(posedge pclk);
      lim(!wait_mode);
      apb(1'b1, `CFDSW_OFF_CCR3, 8'h00);
      periph_irq_req <= 1'b0;
    end
    apb(1'b1, `CFDSW_OFF_CCR0, 8'h40);
  endtask
  task automatic t_shared();
    for (int i = 0; i < 3; i++) begin
      {watchdog_source_flag, volt_mon1_source_flag, volt_mon2_source_flag} <= 3'h1 << i;
      repeat (3) @(posedge pclk);
      rdc(`CFDSW_OFF_STAT, 8'h08, 1'b0);
    end
    {watchdog_source_flag, volt_mon1_source_flag, volt_mon2_source_flag} <= 3'h0;
  endtask
  task automatic t_fail();
    brk <= 1'b1;
    for (int k = 1; k < 3; k++) begin
      apb(1'b1, `CFDSW_OFF_FDCR, 8'(k));
      repeat (100) @(posedge pclk);
      chk(9'(fail_irq), 9'h000);
    end
    brk <= 1'b0;
    apb(1'b1, `CFDSW_OFF_FDCR, 8'h03);
    brk <= 1'b1;
    for (n = 0; n < 300 && fail_irq !== 1'b1; n++) @(posedge pclk);
    lim(fail_irq);
    @(posedge pclk);
    chk(9'({onchip_source_select, low_speed_osc_run}), 9'h003);
    rdc(`CFDSW_OFF_FDCR, 8'h0F, 1'b0);
    rdc(`CFDSW_OFF_STAT, 8'h04, 1'b0);
    brk <= 1'b0;
    repeat (100) @(posedge pclk);
    chk(9'(onchip_source_select), 9'h001);
    apb(1'b1, `CFDSW_OFF_FDCR, 8'h00);
    repeat (4) @(posedge pclk);
    chk(9'({onchip_source_select, fail_irq}), 9'h000);
    // high-speed fallback: start and select it, then stop it again
    apb(1'b1, `CFDSW_OFF_OSCR, 8'h03);
    rdc(`CFDSW_OFF_OSCR, 8'h03, 1'b0);
    chk(9'(high_speed_osc_run), 9'h001);
    apb(1'b1, `CFDSW_OFF_OSCR, 8'h00);
    rdc(`CFDSW_OFF_OSCR, 8'h00, 1'b0);
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_stop();
    t_wait();
    t_shared();
    t_fail();
    print_verdict();
  end
endmodule
`default_nettype wire
